// ### nvram_dev_model.sv
// behavioural model of the memory device on the host pins
`timescale 1ns/1ps
`default_nettype none
module nvram_dev_model (
    input  wire logic                     clk_i,
    input  wire logic                     pwr_fail_i,
    input  wire nvram_host_pkg::mem_ctl_t ctl_i,
    input  wire logic [7:0]               dq_i,
    input  wire logic                     busy_n_i,
    output logic [7:0]                    dq_o,
    output logic                          dq_oe_o,
    output logic                          busy_low_o
);
    logic [7:0] mem [0:131071];
    // power-up restore holds busy low first, so the host must wait for it
    int         store_cnt = 12;
    assign dq_oe_o = !ctl_i.chip_sel_n && !ctl_i.out_drv_n && ctl_i.write_n;
    assign dq_o = mem[ctl_i.addr];
    assign busy_low_o = store_cnt != 0;
    always @(posedge clk_i) begin
        if (!ctl_i.chip_sel_n && !ctl_i.write_n) mem[ctl_i.addr] = dq_i;
        // store outlasts the host pulse so the line stays low throughout
        // a supply loss stores on hold-up capacitor charge, busy low as
        if ((!busy_n_i || pwr_fail_i) && store_cnt == 0) store_cnt <= 6;
        else if (store_cnt != 0) store_cnt <= store_cnt - 1;
    end
endmodule : nvram_dev_model
`default_nettype wire

// ### nvram_host.sv
// host side controller driving the pins of a nonvolatile static ram
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - shared 8-bit data bus: host drives on writes, device drives on reads.
// - chip select is driven low for every access, high when idle.
// - host pulling store busy low starts a store of the whole array.
// - software store and restore requests travel over normal accesses.
module nvram_host (
    input  wire logic                  mclk_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  clk_en_i,
    input  wire nvram_host_pkg::req_t  req_i,
    input  wire logic                  req_valid_i,
    output logic                       req_ready_o,
    input  wire logic                  store_req_i,
    output logic [7:0]                 rdata_o,
    output logic                       rdata_valid_o,
    output logic                       done_o,
    output nvram_host_pkg::mem_ctl_t   mem_ctl_o,
    input  wire logic [7:0]            data_lines_i,
    output logic [7:0]                 data_lines_o,
    output logic                       data_lines_oe_o,
    input  wire logic                  store_busy_n_i,
    output logic                       store_busy_n_o,
    output logic                       store_busy_n_oe_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER, ST_STORE, ST_WAIT}
        state_t;

    state_t                  state_ff;
    state_t                  nxt_state;
    logic [3:0]              cnt_ff;
    logic [3:0]              nxt_cnt;
    logic                    write_ff;
    logic [7:0]              wdata_ff;
    // one-cycle decode strobes shared by the per-concern register blocks
    logic                    take_store;
    logic                    take_access;
    logic                    setup_end;
    logic                    strobe_end;
    logic                    recover_end;
    logic                    pulse_end;
    logic                    store_end;

    // cycle counts as 4-bit constants
    localparam logic [3:0] SETUP_C   = 4'(nvram_host_pkg::SETUP_CYC);
    localparam logic [3:0] STROBE_C  = 4'(nvram_host_pkg::STROBE_CYC);
    localparam logic [3:0] RECOVER_C = 4'(nvram_host_pkg::RECOVER_CYC);
    localparam logic [3:0] STPULSE_C = 4'(nvram_host_pkg::STORE_PULSE_CYC);

    // a phase ends in the cycle its counter stands at one
    function automatic logic last_cycle(input logic [3:0] cnt);
        return (cnt <= 4'h1);
    endfunction : last_cycle

    function automatic logic [3:0] count_down(input logic [3:0] cnt);
        return cnt - 4'h1;
    endfunction : count_down

    // busy low (device store or power-up restore) blocks new accesses
    wire can_start = store_busy_n_i;

    always_comb begin
        take_store  = 1'b0;
        take_access = 1'b0;
        setup_end   = 1'b0;
        strobe_end  = 1'b0;
        recover_end = 1'b0;
        pulse_end   = 1'b0;
        store_end   = 1'b0;
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        case (state_ff)
            ST_IDLE: begin
                // a store request wins over an access offered in the same cycle
                if (can_start && store_req_i) begin
                    take_store = 1'b1;
                    nxt_cnt    = STPULSE_C;
                    nxt_state  = ST_STORE;
                end else if (can_start && req_valid_i && req_ready_o) begin
                    // software store and restore are plain access sequences
                    take_access = 1'b1;
                    nxt_cnt     = SETUP_C;
                    nxt_state   = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (last_cycle(cnt_ff)) begin
                    setup_end = 1'b1;
                    nxt_cnt   = STROBE_C;
                    nxt_state = ST_STROBE;
                end else begin
                    nxt_cnt = count_down(cnt_ff);
                end
            end
            ST_STROBE: begin
                if (last_cycle(cnt_ff)) begin
                    strobe_end = 1'b1;
                    nxt_cnt    = RECOVER_C;
                    nxt_state  = ST_RECOVER;
                end else begin
                    nxt_cnt = count_down(cnt_ff);
                end
            end
            ST_RECOVER: begin
                if (last_cycle(cnt_ff)) begin
                    recover_end = 1'b1;
                    nxt_state   = ST_IDLE;
                end else begin
                    nxt_cnt = count_down(cnt_ff);
                end
            end
            ST_STORE: begin
                if (last_cycle(cnt_ff)) begin
                    pulse_end = 1'b1;
                    nxt_state = ST_WAIT;
                end else begin
                    nxt_cnt = count_down(cnt_ff);
                end
            end
            ST_WAIT: begin
                // device keeps busy low until the store finishes
                if (store_busy_n_i) begin
                    store_end = 1'b1;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 4'h0;
        end else if (clk_en_i) begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // request fields are held locally so the requester may move on
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            write_ff <= 1'b0;
            wdata_ff <= 8'h00;
        end else if (clk_en_i && take_access) begin
            write_ff <= req_i.write;
            wdata_ff <= req_i.wdata;
        end
    end

    // ready is registered, so it trails a falling busy line by one cycle;
    // can_start still gates the take itself
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            req_ready_o <= 1'b0;
        end else if (clk_en_i) begin
            if ((state_ff == ST_IDLE) && !take_store && !take_access) begin
                req_ready_o <= can_start;
            end else begin
                req_ready_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_o       <= 8'h00;
            rdata_valid_o <= 1'b0;
        end else if (clk_en_i) begin
            rdata_valid_o <= strobe_end && !write_ff;
            if (strobe_end && !write_ff) begin
                rdata_o <= data_lines_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            done_o <= 1'b0;
        end else if (clk_en_i) begin
            done_o <= recover_end || store_end;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mem_ctl_o <= '{addr: 17'h00000, chip_sel_n: 1'b1, write_n: 1'b1,
                           out_drv_n: 1'b1};
        end else if (clk_en_i) begin
            if (take_access) begin
                // address and the select fall go out on the same edge, ahead of the strobe
                mem_ctl_o.addr       <= req_i.addr;
                mem_ctl_o.chip_sel_n <= 1'b0;
            end
            if (setup_end) begin
                if (write_ff) begin
                    mem_ctl_o.write_n <= 1'b0;
                end else begin
                    mem_ctl_o.out_drv_n <= 1'b0;
                end
            end
            if (strobe_end) begin
                mem_ctl_o.write_n    <= 1'b1;
                mem_ctl_o.out_drv_n  <= 1'b1;
                mem_ctl_o.chip_sel_n <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            data_lines_o    <= 8'h00;
            data_lines_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            if (setup_end && write_ff) begin
                data_lines_o    <= wdata_ff;
                data_lines_oe_o <= 1'b1;
            end else if (state_ff == ST_RECOVER) begin
                // end strobe before releasing data for hold margin
                data_lines_oe_o <= 1'b0;
            end
        end
    end

    // the busy line is open drain: only ever pulled low, never driven high
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            store_busy_n_o    <= 1'b0;
            store_busy_n_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            if (take_store) begin
                store_busy_n_oe_o <= 1'b1;
            end else if (pulse_end) begin
                store_busy_n_oe_o <= 1'b0;
            end
        end
    end
endmodule : nvram_host
`default_nettype wire

// ### nvram_host_chk.sv
// assertion checker on the host controller ports
`timescale 1ns/1ps
`default_nettype none
module nvram_host_chk (
    input wire logic                     mclk_i,
    input wire logic                     sys_rst_i,
    input wire logic                     clk_en_i,
    input wire nvram_host_pkg::req_t     req_i,
    input wire logic                     req_valid_i,
    input wire logic                     req_ready_o,
    input wire logic                     store_req_i,
    input wire logic                     rdata_valid_o,
    input wire logic                     done_o,
    input wire nvram_host_pkg::mem_ctl_t mem_ctl_o,
    input wire logic                     data_lines_oe_o,
    input wire logic                     store_busy_n_i,
    input wire logic                     store_busy_n_o,
    input wire logic                     store_busy_n_oe_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_rd;
        clk_en_i && store_busy_n_i && req_valid_i && req_ready_o && !store_req_i && !req_i.write;
    endsequence
    sequence s_pulse; store_busy_n_oe_o [*4] ##1 !store_busy_n_oe_o; endsequence
    property p_rd; s_rd |=> !mem_ctl_o.chip_sel_n ##3 rdata_valid_o ##1 done_o; endproperty
    property p_wr; !mem_ctl_o.write_n |-> data_lines_oe_o && !mem_ctl_o.chip_sel_n; endproperty
    property p_clash; data_lines_oe_o |-> mem_ctl_o.out_drv_n; endproperty
    property p_store;
        clk_en_i && store_busy_n_i && store_req_i && req_ready_o |=> s_pulse;
    endproperty
    property p_pull; store_busy_n_oe_o |-> !store_busy_n_o; endproperty
    // ready is a flop, so it drops the cycle after busy falls
    property p_wait; clk_en_i && !store_busy_n_i |=> !req_ready_o; endproperty
    property p_hold;
        clk_en_i && !store_busy_n_i && mem_ctl_o.chip_sel_n |=> mem_ctl_o.chip_sel_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read sequence wrong");
    a_wr: assert property (p_wr) else $error("write without bus drive");
    a_clash: assert property (p_clash) else $error("bus contention");
    a_store: assert property (p_store) else $error("store pulse wrong");
    a_pull: assert property (p_pull) else $error("busy line not pulled low");
    a_wait: assert property (p_wait) else $error("access while busy");
    a_hold: assert property (p_hold) else $error("select while busy");
endmodule : nvram_host_chk
`default_nettype wire

// ### nvram_host_pkg.sv
// package for the nonvolatile static ram host controller
package nvram_host_pkg;
    localparam int ADDR_W       = 17;
    localparam int DATA_W       = 8;
    // access phase lengths in ns, counts derived at 50 ns clock
    localparam int CLK_PERIOD_NS = 50;
    localparam int SETUP_NS     = 50;
    localparam int STROBE_NS    = 100;
    localparam int RECOVER_NS   = 50;
    localparam int SETUP_CYC    = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC  = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cycles the host holds the busy line low to request a store
    localparam int STORE_PULSE_CYC = 4;
    localparam int CNT_W        = 4;

    typedef struct packed {
        logic              write;
        logic [16:0]       addr;
        logic [7:0]        wdata;
    } req_t;

    typedef struct packed {
        logic [16:0]       addr;
        logic              chip_sel_n;
        logic              write_n;
        logic              out_drv_n;
    } mem_ctl_t;
endpackage : nvram_host_pkg

// ### nvram_host_tb_top.sv
// testbench for the nonvolatile static ram host controller
`timescale 1ns/1ps
`default_nettype none
module nvram_host_tb_top;
    logic                     mclk_i = 0, sys_rst_i = 1, req_valid_i = 0, store_req_i = 0;
    nvram_host_pkg::req_t     req_i = '0;
    nvram_host_pkg::mem_ctl_t mem_ctl_o;
    logic [7:0]               rdata_o, dq_w, host_dq, dev_dq;
    logic                     req_ready_o, rdata_valid_o, done_o, host_oe, dev_oe, busy_oe;
    logic                     dev_busy, busy_w, seen, busy_o;
    logic                     clk_en_i = 1, pwr_fail = 0;
    int                       mismatches = 0, tests_run = 0;
    always #25 mclk_i = ~mclk_i;
    // a released bus toggles so stale data cannot pass for a read
    assign dq_w = host_oe ? host_dq : dev_oe ? dev_dq : 8'h5A ^ {8{mclk_i}};
    assign busy_w = !((busy_oe && !busy_o) || dev_busy);
    nvram_host i_nvram_host (.mclk_i, .sys_rst_i, .clk_en_i, .req_i, .req_valid_i,
        .req_ready_o, .store_req_i, .rdata_o, .rdata_valid_o, .done_o, .mem_ctl_o,
        .data_lines_i(dq_w), .data_lines_o(host_dq), .data_lines_oe_o(host_oe),
        .store_busy_n_i(busy_w), .store_busy_n_o(busy_o), .store_busy_n_oe_o(busy_oe));
    nvram_dev_model i_nvram_dev_model (.clk_i(mclk_i), .pwr_fail_i(pwr_fail),
        .ctl_i(mem_ctl_o), .dq_i(dq_w),
        .busy_n_i(busy_w), .dq_o(dev_dq), .dq_oe_o(dev_oe), .busy_low_o(dev_busy));
    task automatic wrap_up();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic step(inout int n);
        @(posedge mclk_i);
        #2;
        n++;
        if (n > 60) begin
            mismatches++;
            wrap_up();
        end
    endtask : step
    task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d);
        int n;
        logic vld;
        n = 0;
        vld = 0;
        req_i = '{wr, a, d};
        req_valid_i = 1;
        while (req_ready_o !== 1'b1) step(n);
        step(n);
        req_valid_i = 0;
        while (done_o !== 1'b1) begin
            vld = vld | rdata_valid_o;
            step(n);
        end
        if (!wr) chk8(rdata_o, d);
        chk8({7'h00, vld}, {7'h00, !wr});
    endtask : access
    task automatic t_wr_rd();
        logic [16:0] adr [4];
        adr = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h15555};
        foreach (adr[i]) access(1'b1, adr[i], adr[i][7:0] ^ 8'hC3);
        foreach (adr[i]) access(1'b0, adr[i], adr[i][7:0] ^ 8'hC3);
    endtask : t_wr_rd
    task automatic t_store();
        int n;
        n = 0;
        seen = 0;
        while (req_ready_o !== 1'b1) step(n);
        store_req_i = 1;
        step(n);
        store_req_i = 0;
        repeat (4) begin
            seen = seen | !busy_w;
            step(n);
        end
        chk8({7'h00, seen}, 8'h01);
        access(1'b0, 17'h1FFFF, 8'h3C);
    endtask : t_store
    task automatic t_freeze();
        int n;
        n = 0;
        while (req_ready_o !== 1'b1) step(n);
        clk_en_i = 0;
        req_i = '{1'b0, 17'h0AAAA, 8'h00};
        req_valid_i = 1;
        repeat (4) step(n);
        chk8({7'h00, mem_ctl_o.chip_sel_n}, 8'h01);
        clk_en_i = 1;
        req_valid_i = 0;
        step(n);
        access(1'b0, 17'h0AAAA, 8'h69);
    endtask : t_freeze
    task automatic t_pwr();
        int n;
        n = 0;
        while (req_ready_o !== 1'b1) step(n);
        pwr_fail = 1;
        step(n);
        pwr_fail = 0;
        step(n);
        chk8({7'h00, req_ready_o}, 8'h00);
        access(1'b0, 17'h00000, 8'hC3);
    endtask : t_pwr
    initial begin
        repeat (8) @(posedge mclk_i);
        #2;
        sys_rst_i = 0;
        @(posedge mclk_i);
        #2;
        chk8({7'h00, req_ready_o}, 8'h00);
        t_wr_rd();
        t_store();
        t_freeze();
        t_pwr();
        wrap_up();
    end
endmodule : nvram_host_tb_top
bind nvram_host nvram_host_chk i_nvram_host_chk (.mclk_i, .sys_rst_i, .clk_en_i, .req_i,
    .req_valid_i,
    .req_ready_o, .store_req_i, .rdata_valid_o, .done_o, .mem_ctl_o, .data_lines_oe_o,
    .store_busy_n_i, .store_busy_n_o, .store_busy_n_oe_o);
`default_nettype wire
